// file: rtl/ram_ctrl_pkg.sv
package ram_ctrl_pkg;
  `include "ram_ctrl_regs.svh"

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_RECOV = 3'b010
  } phase_e;

  typedef struct packed
  {
    logic write;
    logic [`SEL_W-1:0] bank;
    logic [`ADDR_W-1:0] word_address;
    logic data;
  } req_s;

  typedef struct packed
  {
    logic [`ADDR_W-1:0] word_address;
    logic data_in;
    logic write_strobe_n;
    logic [(1<<`SEL_W)-1:0] array_select_n;
  } pins_s;
endpackage

// file: rtl/ram_ctrl_regs.svh
`ifndef RAM_CTRL_REGS_SVH
`define RAM_CTRL_REGS_SVH

`define CLK_PERIOD_NS 20
// read delay: address access 45 ns (slow grade 60 ns)
`define T_ACCESS_NS 60
`define ACCESS_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// write pulse: 30 ns (slow grade 40 ns)
`define T_WPULSE_NS 40
`define WPULSE_CYC ((`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// setup of address/data/select ahead of strobe: 15 ns worst
`define T_SETUP_NS 15
`define SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// hold/recovery after strobe: 50 ns worst
`define T_RECOV_NS 50
`define RECOV_CYC ((`T_RECOV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W 10
`define SEL_W 2
`define CNT_W 3

`endif

// file: rtl/ram_host_ctrl.sv
`timescale 1ns/1ps
`include "ram_ctrl_regs.svh"

module ram_host_ctrl
  import ram_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire req_s req,
  output logic rsp_valid,
  output logic rsp_data,
  output pins_s pins,
  input wire logic data_out_node
);

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================
  // one-hot low-active select from the upper address bits
  function automatic logic [(1<<`SEL_W)-1:0] bank_select_n(input logic [`SEL_W-1:0] bank);
    logic [(1<<`SEL_W)-1:0] sel;
    sel = '1;
    sel[bank] = 1'b0;
    return sel;
  endfunction

  // shared by every timed phase so all of them count down the same way
  function automatic logic [`CNT_W-1:0] count_down(input logic [`CNT_W-1:0] cnt);
    return cnt - 3'h1;
  endfunction

  // length of each timed phase, minus one since the counter stops at zero
  function automatic logic [`CNT_W-1:0] phase_len(input phase_e ph, input logic write);
    logic [`CNT_W-1:0] len;
    len = 3'h0;
    case (ph)
      ST_SETUP: len = 3'(`SETUP_CYC - 1);
      ST_STROBE: len = write ? 3'(`WPULSE_CYC - 1) : 3'(`ACCESS_CYC - 1);
      ST_RECOV: len = 3'(`RECOV_CYC - 1);
      default: len = 3'h0;
    endcase
    return len;
  endfunction

  // ==========================================================
  // sequencer
  phase_e state_r;
  phase_e state_nxt;
  logic [`CNT_W-1:0] cnt_r;
  logic [`CNT_W-1:0] cnt_nxt;
  req_s cur_r;
  req_s next_req;
  logic take;
  logic last;

  assign last = (cnt_r == 3'h0);
  assign req_ready = (state_r == ST_IDLE);
  assign take = req_valid && req_ready;

  // the pins load from the request in the cycle it is taken, so address,
  // data and select lead the falling strobe by a whole clock
  assign next_req = take ? req : cur_r;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      ST_IDLE:
        if (take)
        begin
          state_nxt = ST_SETUP;
          cnt_nxt = phase_len(ST_SETUP, req.write);
        end
      ST_SETUP:
        if (last)
        begin
          state_nxt = ST_STROBE;
          cnt_nxt = phase_len(ST_STROBE, cur_r.write);
        end
        else
          cnt_nxt = count_down(cnt_r);
      ST_STROBE:
        if (last)
        begin
          state_nxt = ST_RECOV;
          cnt_nxt = phase_len(ST_RECOV, cur_r.write);
        end
        else
          cnt_nxt = count_down(cnt_r);
      ST_RECOV:
        if (last)
          state_nxt = ST_IDLE;
        else
          cnt_nxt = count_down(cnt_r);
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_nxt;
  end

  // address and data stay stable across setup, strobe and hold
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cur_r <= '0;
    else if (take)
      cur_r <= req;
  end

  // ==========================================================
  // pins
  logic [`ADDR_W-1:0] addr_r;
  logic din_r;
  logic strobe_n_r;
  logic [(1<<`SEL_W)-1:0] select_n_r;
  logic strobe_n_nxt;
  logic [(1<<`SEL_W)-1:0] select_n_nxt;

  // strobe only inside the select window, so setup and hold stay clean
  assign strobe_n_nxt = !(state_nxt == ST_STROBE && next_req.write);
  // only one bank selected at a time keeps the wired-AND node unambiguous
  assign select_n_nxt = (state_nxt == ST_IDLE) ? '1
                        : bank_select_n(next_req.bank);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      addr_r <= '0;
    else
      addr_r <= next_req.word_address;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      din_r <= 1'b0;
    else
      din_r <= next_req.data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      strobe_n_r <= 1'b1;
    else
      strobe_n_r <= strobe_n_nxt;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      select_n_r <= '1;
    else
      select_n_r <= select_n_nxt;
  end

  // flops straight to the pins, no gate between them and the devices
  assign pins = '{
    word_address: addr_r,
    data_in: din_r,
    write_strobe_n: strobe_n_r,
    array_select_n: select_n_r
  };

  // ==========================================================
  // read capture at the last access cycle; the node is true data and the
  // pull-up leaves it high whenever no selected device pulls it low
  logic sample;

  assign sample = (state_r == ST_STROBE) && last && !cur_r.write;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rsp_valid <= 1'b0;
    else
      rsp_valid <= sample;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rsp_data <= 1'b0;
    else if (sample)
      rsp_data <= data_out_node;
  end

endmodule

// file: tb/ram_dev_model.sv
`timescale 1ns/1ps
module ram_dev_model
  import ram_ctrl_pkg::*;
(
  input pins_s pins,
  output logic node
);
  logic mem [4][1024];
  always_comb
  begin
    node = 1'h1;
    for (int i = 0; i < 4; i++)
      if (!pins.array_select_n[i] && pins.write_strobe_n)
        node &= mem[i][pins.word_address];
  end
  always @(pins)
    for (int i = 0; i < 4; i++)
      if (!pins.array_select_n[i] && !pins.write_strobe_n)
        mem[i][pins.word_address] = pins.data_in;
endmodule

// file: tb/ram_host_ctrl_props.sv
`timescale 1ns/1ps
module ram_host_ctrl_props
  import ram_ctrl_pkg::*;
(
  input logic mclk,
  input logic nrst,
  input logic req_valid,
  input logic req_ready,
  input req_s req,
  input logic rsp_valid,
  input logic rsp_data,
  input pins_s pins,
  input logic data_out_node
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence pulse_2;
    (!pins.write_strobe_n)[*2] ##1 pins.write_strobe_n;
  endsequence
  sequence read_quiet;
    (pins.write_strobe_n)[*7];
  endsequence
  a_one_device: assert property ($onehot0(~pins.array_select_n)) else $error("two selects");
  a_pulse_len: assert property ($fell(pins.write_strobe_n) |-> pulse_2) else $error("pulse");
  a_strobe_sel: assert property (!pins.write_strobe_n |-> !(&pins.array_select_n))
    else $error("strobe unselected");
  a_read_ans: assert property (req_valid && req_ready && !req.write |-> ##[4:8] rsp_valid)
    else $error("no read answer");
  a_pins_setup: assert property (!pins.write_strobe_n |-> $stable(pins.word_address)
    && $stable(pins.data_in) && $stable(pins.array_select_n))
    else $error("pins moved under strobe");
  a_read_quiet: assert property (req_valid && req_ready && !req.write |=> read_quiet)
    else $error("strobe during read");
endmodule
bind ram_host_ctrl ram_host_ctrl_props ram_host_ctrl_props_i (.*);

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import ram_ctrl_pkg::*;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic req_valid = 1'h0;
  logic req_ready, rsp_valid, rsp_data, node;
  req_s req = '0;
  pins_s pins;
  int errors = 0;
  int total_checks = 0;
  always #10 mclk = ~mclk;
  ram_host_ctrl ram_host_ctrl_i (
    .mclk(mclk),
    .nrst(nrst),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req(req),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .pins(pins),
    .data_out_node(node)
  );
  ram_dev_model ram_dev_model_i (
    .pins(pins),
    .node(node)
  );
  task check(string s, logic e, logic v);
    total_checks++;
    if (v !== e)
    begin
      errors++;
      $display("unexpected %s exp %b seen %b", s, e, v);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // on reads d is the expected bit, since the data field is ignored then
  task acc(logic w, logic [1:0] b, logic [9:0] a, logic d);
    repeat (20) if (req_ready !== 1'h1) @(negedge mclk);
    check("req_ready", 1'h1, req_ready);
    req_valid = 1'h1;
    req = '{w, b, a, d};
    @(negedge mclk);
    req_valid = 1'h0;
    repeat (20) if (!w && rsp_valid !== 1'h1) @(negedge mclk);
    if (!w) check("rsp_valid", 1'h1, rsp_valid);
    if (!w) check("read bit", d, rsp_data);
  endtask
  task t_store;
    for (int b = 0; b < 4; b++)
    begin
      acc(1'h1, b[1:0], 10'h000, b[0]);
      acc(1'h1, b[1:0], 10'h3ff, !b[0]);
    end
    for (int b = 0; b < 4; b++)
    begin
      acc(1'h0, b[1:0], 10'h000, b[0]);
      acc(1'h0, b[1:0], 10'h3ff, !b[0]);
    end
    $display("store end");
  endtask
  task t_overwrite;
    acc(1'h1, 2'h2, 10'h155, 1'h1);
    acc(1'h1, 2'h2, 10'h155, 1'h0);
    acc(1'h0, 2'h2, 10'h155, 1'h0);
    repeat (10) @(negedge mclk);
    check("idle select", 1'h1, &pins.array_select_n);
    check("idle node", 1'h1, node);
    $display("overwrite end");
  endtask
  initial
  begin
    repeat (2) @(negedge mclk);
    nrst = 1'h1;
    repeat (3) @(negedge mclk);
    t_store();
    t_overwrite();
    test_done();
  end
  initial
  begin
    #20000;
    errors++;
    test_done();
  end
endmodule
